// ### common/csfr_pkg.sv
// Shared constants and types of the core special function register block
package csfr_pkg;
   // Register byte addresses in the special function space
   localparam logic [7:0] ADDR_SP = 8'h81;
   localparam logic [7:0] ADDR_PTR_LO = 8'h82;
   localparam logic [7:0] ADDR_PTR_HI = 8'h83;
   localparam logic [7:0] ADDR_PSEL = 8'ha2;
   localparam logic [7:0] ADDR_PMAP = 8'hc0;
   localparam logic [7:0] ADDR_PSW = 8'hd0;
   localparam logic [7:0] ADDR_ACC = 8'he0;
   localparam logic [7:0] ADDR_MULH = 8'hf0;

   // Reset values
   localparam logic [7:0] RST_SP = 8'h07;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic RST_ROM_MAP = 1'b1;
   localparam logic RST_PSEL = 1'b0;

   // Field positions
   localparam int PSW_CARRY = 7;
   localparam int PSW_HALF = 6;
   localparam int PSW_WRAP = 2;
   localparam int PSW_P = 0;
   localparam int PSW_GRP_HI = 4;
   localparam int PSW_GRP_LO = 3;
   localparam int PMAP_BOOT = 4;
   localparam int PMAP_ROM = 1;
   localparam int PSEL_BIT = 0;

   // Bit-addressable registers have these low address bits clear
   localparam logic [2:0] BIT_ADDR_LOW = 3'h0;

   // Mode pins pattern for in-system programming
   localparam logic [2:0] MODE_PROG = 3'h4;

   // Upper program area served by boot ROM
   localparam logic [15:0] ROM_BASE = 16'hfc00;

   // Internal data area: groups 0x00-0x1f, stack up to 0x7f
   localparam int IRAM_AW = 7;
   localparam int IRAM_DEPTH = 128;
   localparam logic [7:0] SP_STEP = 8'h01;

   // Core operations handed to the block
   typedef enum logic [2:0] {
      OP_PUSH,
      OP_POP,
      OP_MUL,
      OP_DIV,
      OP_ADD,
      OP_ADDC,
      OP_SUBB
   } csfr_op_t;
endpackage

// ### hw/csfr_alu.sv
// Arithmetic unit: add, subtract with borrow, multiply, divide
`timescale 1ns/1ps
module csfr_alu (
   // Operation and operands
   input wire csfr_pkg::csfr_op_t op,
   input wire logic [7:0] acc,
   input wire logic [7:0] mulh,
   input wire logic [7:0] operand,
   input wire logic [7:0] psw_in,
   // Results
   output logic [7:0] res_acc,
   output logic [7:0] res_mulh,
   output logic [7:0] psw_out
);
   logic [8:0] wide;
   logic [4:0] nib;
   logic [15:0] prod;
   logic cin;

   always_comb begin
      cin = 1'b0;
      wide = 9'h000;
      nib = 5'h00;
      prod = 16'h0000;
      res_acc = acc;
      res_mulh = mulh;
      psw_out = psw_in;
      if (op == csfr_pkg::OP_ADDC || op == csfr_pkg::OP_SUBB) begin
         cin = psw_in[csfr_pkg::PSW_CARRY];
      end
      unique case (op)
         csfr_pkg::OP_ADD, csfr_pkg::OP_ADDC: begin
            wide = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
            nib = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
            res_acc = wide[7:0];
            // Family flags: carry out, nibble carry, signed wrap
            psw_out[csfr_pkg::PSW_CARRY] = wide[8];
            psw_out[csfr_pkg::PSW_HALF] = nib[4];
            psw_out[csfr_pkg::PSW_WRAP] = (acc[7] == operand[7]) &&
                                        (wide[7] != acc[7]);
         end
         csfr_pkg::OP_SUBB: begin
            wide = {1'b0, acc} - {1'b0, operand} - {8'h00, cin};
            nib = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, cin};
            res_acc = wide[7:0];
            psw_out[csfr_pkg::PSW_CARRY] = wide[8];
            psw_out[csfr_pkg::PSW_HALF] = nib[4];
            psw_out[csfr_pkg::PSW_WRAP] = (acc[7] != operand[7]) &&
                                        (wide[7] != acc[7]);
         end
         csfr_pkg::OP_MUL: begin
            prod = {8'h00, acc} * {8'h00, mulh};
            res_acc = prod[7:0];
            res_mulh = prod[15:8];
            psw_out[csfr_pkg::PSW_CARRY] = 1'b0;
            psw_out[csfr_pkg::PSW_WRAP] = (prod[15:8] != 8'h00);
         end
         csfr_pkg::OP_DIV: begin
            psw_out[csfr_pkg::PSW_CARRY] = 1'b0;
            psw_out[csfr_pkg::PSW_WRAP] = (acc == 8'h00);
            // Zero divisor leaves both registers unchanged
            if (acc != 8'h00) begin
               res_mulh = mulh % acc;
               res_acc = mulh / acc;
            end
         end
         default: begin
            res_acc = acc;
         end
      endcase
   end
endmodule // csfr_alu

// ### hw/csfr_iram.sv
// Internal data memory: working register groups and stack area
`timescale 1ns/1ps
module csfr_iram (
   // Clock
   input wire logic sys_clk,
   // Single access port, read data one cycle later
   input wire logic we,
   input wire logic [csfr_pkg::IRAM_AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:csfr_pkg::IRAM_DEPTH-1];

   // No reset: contents are undefined after power-up
   always_ff @(posedge sys_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule // csfr_iram

// ### hw/csfr_core.sv
// Core special function registers with stack, pointers and program map
//
// Overview of operation
// - Boot indication bit 4 reads 1 when mode pins carry 100.
// - Upper-ROM map bit 1 maps 0xfc00-0xffff to ROM; resets to 1.
// - Upper-ROM map bit only acts in programming mode.
// - Arithmetic main register: 8-bit, read/write, resets to zero.
// - Multiply puts high byte in partner, low byte in main.
// - Divide takes dividend from partner, leaves remainder there.
// - Divide takes divisor from main, leaves quotient there.
// - Status word: carry, half carry, user flags, group, wrap, odd-ones.
// - Odd-ones flag follows parity of the main register.
// - Push increments stack pointer then stores at new address.
// - Pop reads at current address then decrements pointer.
// - Stack pointer is 8-bit read/write, resets to 0x07.
// - Stack lives in internal data area 0x08 to 0x7f.
// - Data pointer: high and low byte, 16-bit or byte access.
// - Two data pointers; select bit picks which one is visible.
// - Four groups of eight registers at 0x00-0x1f, group zero at reset.
// - Unimplemented locations ignore writes and read zero.
// - Programming mode boots with upper 1KB on ROM; else memory.
// - Byte access everywhere, bit access at multiples of eight.
`timescale 1ns/1ps
module csfr_core (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Special function register access
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic sfr_bit_en,
   input wire logic [2:0] sfr_bit_sel,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_rd_ack,
   // Core operations
   input wire logic op_valid,
   input wire csfr_pkg::csfr_op_t op_code,
   input wire logic [7:0] op_data,
   output logic op_done,
   output logic [7:0] pop_data,
   // Working register access in the selected group
   input wire logic wreg_wr,
   input wire logic wreg_rd,
   input wire logic [2:0] wreg_idx,
   input wire logic [7:0] wreg_wdata,
   output logic [7:0] wreg_rdata,
   output logic wreg_ack,
   // Full data pointer access
   input wire logic dptr_wr,
   input wire logic [15:0] dptr_wdata,
   output logic [15:0] dptr_value,
   // Program map
   input wire logic [2:0] mode_select_pins,
   input wire logic [15:0] prog_addr,
   output logic prog_rom_sel,
   output logic in_system_prog,
   // Visible core state
   output logic [7:0] acc_value,
   output logic [7:0] psw_value,
   output logic [7:0] sp_value,
   output logic [1:0] reg_group
);
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] mulh;
      logic [7:0] program_status_word;
      logic [7:0] sp;
      logic [7:0] dpl0;
      logic [7:0] dph0;
      logic [7:0] dpl1;
      logic [7:0] dph1;
      logic psel;
      logic rom_map;
      logic [2:0] mode_s1;
      logic [2:0] mode_s2;
      logic boot;
      logic rom_sel;
      logic [15:0] dptr_out;
      logic [7:0] rdata;
      logic rd_ack;
      logic pop_pend;
      logic op_done;
      logic [7:0] pop_data;
      logic wreg_pend;
      logic [7:0] wreg_rdata;
      logic wreg_ack;
   } csfr_state_t;

   csfr_state_t st;
   csfr_state_t next_st;
   logic ram_we;
   logic [csfr_pkg::IRAM_AW-1:0] ram_addr;
   logic [7:0] ram_wdata;
   logic [7:0] ram_rdata;
   logic [7:0] alu_acc;
   logic [7:0] alu_mulh;
   logic [7:0] alu_psw;
   logic bit_ok;
   logic [7:0] wbyte;

   // Byte view of a register as software reads it
   function automatic logic [7:0] sfr_view(input csfr_state_t s,
                                           input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         csfr_pkg::ADDR_SP: v = s.sp;
         csfr_pkg::ADDR_PTR_LO: v = s.psel ? s.dpl1 : s.dpl0;
         csfr_pkg::ADDR_PTR_HI: v = s.psel ? s.dph1 : s.dph0;
         csfr_pkg::ADDR_PSEL: v[csfr_pkg::PSEL_BIT] = s.psel;
         csfr_pkg::ADDR_PMAP: begin
            v[csfr_pkg::PMAP_BOOT] = s.boot;
            v[csfr_pkg::PMAP_ROM] = s.rom_map;
         end
         csfr_pkg::ADDR_PSW: v = s.program_status_word;
         csfr_pkg::ADDR_ACC: v = s.acc;
         csfr_pkg::ADDR_MULH: v = s.mulh;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // New byte after a byte write or a single-bit write
   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] wd,
                                        input logic be,
                                        input logic [2:0] sel);
      logic [7:0] v;
      v = wd;
      if (be) begin
         v = old;
         v[sel] = wd[0];
      end
      return v;
   endfunction

   csfr_alu u_alu (
      .op(op_code),
      .acc(st.acc),
      .mulh(st.mulh),
      .operand(op_data),
      .psw_in(st.program_status_word),
      .res_acc(alu_acc),
      .res_mulh(alu_mulh),
      .psw_out(alu_psw)
   );

   csfr_iram u_iram (
      .sys_clk(sys_clk),
      .we(ram_we),
      .addr(ram_addr),
      .wdata(ram_wdata),
      .rdata(ram_rdata)
   );

   // Bit access only at multiples of eight
   assign bit_ok = !sfr_bit_en || (sfr_addr[2:0] == csfr_pkg::BIT_ADDR_LOW);
   assign wbyte = merge(sfr_view(st, sfr_addr), sfr_wdata, sfr_bit_en,
                        sfr_bit_sel);

   always_comb begin
      next_st = st;
      next_st.op_done = 1'b0;
      next_st.wreg_ack = 1'b0;
      next_st.rd_ack = 1'b0;
      // Mode pins come from outside: two flip-flops first
      next_st.mode_s1 = mode_select_pins;
      next_st.mode_s2 = st.mode_s1;
      next_st.boot = (st.mode_s2 == csfr_pkg::MODE_PROG);
      ram_we = 1'b0;
      ram_addr = {2'b00,
                  st.program_status_word[csfr_pkg::PSW_GRP_HI:csfr_pkg::PSW_GRP_LO],
                  wreg_idx};
      ram_wdata = wreg_wdata;

      if (st.wreg_pend) begin
         next_st.wreg_rdata = ram_rdata;
         next_st.wreg_ack = 1'b1;
         next_st.wreg_pend = 1'b0;
      end

      if (st.pop_pend) begin
         next_st.pop_data = ram_rdata;
         next_st.sp = st.sp - csfr_pkg::SP_STEP;
         next_st.pop_pend = 1'b0;
         next_st.op_done = 1'b1;
      end else if (op_valid) begin
         unique case (op_code)
            csfr_pkg::OP_PUSH: begin
               // Increment, then store at new top
               next_st.sp = st.sp + csfr_pkg::SP_STEP;
               ram_addr = next_st.sp[csfr_pkg::IRAM_AW-1:0];
               ram_wdata = op_data;
               ram_we = 1'b1;
               next_st.op_done = 1'b1;
            end
            csfr_pkg::OP_POP: begin
               ram_addr = st.sp[csfr_pkg::IRAM_AW-1:0];
               next_st.pop_pend = 1'b1;
            end
            default: begin
               next_st.acc = alu_acc;
               next_st.mulh = alu_mulh;
               next_st.program_status_word = alu_psw;
               next_st.op_done = 1'b1;
            end
         endcase
      end else if (!st.wreg_pend && (wreg_wr || wreg_rd)) begin
         // Any operation or pending pop has the port first; a group request then is dropped
         ram_we = wreg_wr;
         next_st.wreg_pend = wreg_rd && !wreg_wr;
         next_st.wreg_ack = wreg_wr;
      end

      // Whole pointer write goes to the selected pointer
      if (dptr_wr) begin
         if (st.psel) begin
            {next_st.dph1, next_st.dpl1} = dptr_wdata;
         end else begin
            {next_st.dph0, next_st.dpl0} = dptr_wdata;
         end
      end

      // Unlisted addresses fall through with no effect
      if (sfr_wr && bit_ok) begin
         unique case (sfr_addr)
            csfr_pkg::ADDR_SP: next_st.sp = wbyte;
            // Only the selected pointer is touched
            csfr_pkg::ADDR_PTR_LO: begin
               if (st.psel) begin
                  next_st.dpl1 = wbyte;
               end else begin
                  next_st.dpl0 = wbyte;
               end
            end
            csfr_pkg::ADDR_PTR_HI: begin
               if (st.psel) begin
                  next_st.dph1 = wbyte;
               end else begin
                  next_st.dph0 = wbyte;
               end
            end
            csfr_pkg::ADDR_PSEL: next_st.psel = wbyte[csfr_pkg::PSEL_BIT];
            csfr_pkg::ADDR_PMAP: next_st.rom_map = wbyte[csfr_pkg::PMAP_ROM];
            csfr_pkg::ADDR_PSW: next_st.program_status_word = wbyte;
            csfr_pkg::ADDR_ACC: next_st.acc = wbyte;
            csfr_pkg::ADDR_MULH: next_st.mulh = wbyte;
            default: next_st.acc = next_st.acc;
         endcase
      end

      // Odd-ones flag always tracks the main register
      next_st.program_status_word[csfr_pkg::PSW_P] = ^next_st.acc;

      next_st.dptr_out = next_st.psel ? {next_st.dph1, next_st.dpl1}
                                      : {next_st.dph0, next_st.dpl0};

      // Map bit honoured only in programming mode
      // Upper area goes to ROM when mapped
      next_st.rom_sel = next_st.boot && next_st.rom_map &&
                        (prog_addr >= csfr_pkg::ROM_BASE);

      if (sfr_rd) begin
         next_st.rd_ack = 1'b1;
         next_st.rdata = 8'h00;
         if (bit_ok) begin
            next_st.rdata = sfr_view(st, sfr_addr);
            if (sfr_bit_en) begin
               next_st.rdata = {7'h00, next_st.rdata[sfr_bit_sel]};
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st <= '0;
         st.sp <= csfr_pkg::RST_SP;
         st.acc <= csfr_pkg::RST_BYTE;
         st.mulh <= csfr_pkg::RST_BYTE;
         st.program_status_word <= csfr_pkg::RST_BYTE;
         st.psel <= csfr_pkg::RST_PSEL;
         // Boots with upper area on ROM when in programming mode
         st.rom_map <= csfr_pkg::RST_ROM_MAP;
      end else begin
         st <= next_st;
      end
   end

   assign sfr_rdata = st.rdata;
   assign sfr_rd_ack = st.rd_ack;
   assign op_done = st.op_done;
   assign pop_data = st.pop_data;
   assign wreg_rdata = st.wreg_rdata;
   assign wreg_ack = st.wreg_ack;
   assign dptr_value = st.dptr_out;
   assign prog_rom_sel = st.rom_sel;
   assign in_system_prog = st.boot;
   assign acc_value = st.acc;
   assign psw_value = st.program_status_word;
   assign sp_value = st.sp;
   assign reg_group = st.program_status_word[csfr_pkg::PSW_GRP_HI:csfr_pkg::PSW_GRP_LO];
endmodule // csfr_core

// ### tb/csfr_core_props.sv
// Concurrent checks on the ports of the core register block
`timescale 1ns/1ps
module csfr_core_props (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Register access and operations
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic sfr_rd_ack,
   input wire logic op_valid,
   input wire csfr_pkg::csfr_op_t op_code,
   input wire logic op_done,
   // Pointers and program map
   input wire logic dptr_wr,
   input wire logic [15:0] dptr_wdata,
   input wire logic [15:0] dptr_value,
   input wire logic [2:0] mode_select_pins,
   input wire logic [15:0] prog_addr,
   input wire logic prog_rom_sel,
   input wire logic in_system_prog,
   // Visible core state
   input wire logic [7:0] acc_value,
   input wire logic [7:0] psw_value,
   input wire logic [7:0] sp_value,
   input wire logic [1:0] reg_group
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   // A taken pop swallows any operation or group request in the next cycle
   sequence push_req;
      op_valid && op_code == csfr_pkg::OP_PUSH && !sfr_wr &&
         !$past(op_valid && op_code == csfr_pkg::OP_POP);
   endsequence
   sequence pop_req;
      op_valid && op_code == csfr_pkg::OP_POP && !sfr_wr &&
         !$past(op_valid && op_code == csfr_pkg::OP_POP);
   endsequence
   sequence pop_done;
      ##2 op_done && sp_value == $past(sp_value, 2) - 8'h01;
   endsequence

   rd_ack_a: assert property (sfr_rd_ack == $past(sfr_rd))
      else $error("read acknowledge not one cycle after read");
   parity_flag_a: assert property (psw_value[0] == ^acc_value)
      else $error("odd-ones flag differs from main register");
   group_view_a: assert property (reg_group == psw_value[4:3])
      else $error("group output differs from status word");
   push_step_a: assert property (push_req |=>
      op_done && sp_value == $past(sp_value) + 8'h01)
      else $error("push did not raise stack pointer by one");
   pop_step_a: assert property (pop_req |-> pop_done)
      else $error("pop did not lower stack pointer in two cycles");
   dptr_load_a: assert property (dptr_wr && !sfr_wr |=>
      dptr_value == $past(dptr_wdata))
      else $error("pointer write not seen next cycle");
   // Select and mode flag are loaded at the same edge
   rom_map_a: assert property (prog_rom_sel |->
      in_system_prog && $past(prog_addr >= 16'hfc00))
      else $error("boot area selected outside its range or mode");
   isp_detect_a: assert property (in_system_prog |->
      $past(mode_select_pins, 3) == 3'h4)
      else $error("programming mode without its pin pattern");
   reset_state_a: assert property ($fell(sys_rst) |->
      sp_value == 8'h07 && acc_value == 8'h00 && psw_value == 8'h00)
      else $error("register state wrong after reset");
endmodule // csfr_core_props

bind csfr_core csfr_core_props u_props (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd), .sfr_rd_ack(sfr_rd_ack), .op_valid(op_valid),
   .op_code(op_code), .op_done(op_done), .dptr_wr(dptr_wr),
   .dptr_wdata(dptr_wdata), .dptr_value(dptr_value),
   .mode_select_pins(mode_select_pins), .prog_addr(prog_addr),
   .prog_rom_sel(prog_rom_sel), .in_system_prog(in_system_prog),
   .acc_value(acc_value), .psw_value(psw_value),
   .sp_value(sp_value), .reg_group(reg_group)
);

// ### tb/tb.sv
// Self-checking testbench of the core register block
`timescale 1ns/1ps
module tb;
   logic sys_clk, sys_rst, sfr_wr, sfr_rd, sfr_bit_en, op_valid, dptr_wr;
   logic wreg_wr, wreg_rd, sfr_rd_ack, op_done, wreg_ack;
   logic prog_rom_sel, in_system_prog;
   logic [1:0] reg_group;
   logic [2:0] sfr_bit_sel, wreg_idx, mode_select_pins;
   logic [7:0] sfr_addr, sfr_wdata, op_data, wreg_wdata, sfr_rdata;
   logic [7:0] pop_data, wreg_rdata, acc_value, psw_value, sp_value, q;
   logic [15:0] dptr_wdata, prog_addr, dptr_value;
   csfr_pkg::csfr_op_t op_code;
   int failures, comparisons;
   // Register map walk, last entry is an unmapped hole
   localparam logic [71:0] REG_AD = 72'h81_82_83_a2_c0_d0_e0_f0_85;
   localparam logic [71:0] RST_EXP = 72'h07_00_00_00_02_00_00_00_00;
   // Pointer bytes read 0 here: pointer one is selected by then
   localparam logic [71:0] RW_EXP = 72'hff_00_00_01_02_fe_ff_ff_00;

   csfr_core DUT (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_bit_en(sfr_bit_en),
      .sfr_bit_sel(sfr_bit_sel), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .sfr_rd_ack(sfr_rd_ack),
      .op_valid(op_valid), .op_code(op_code), .op_data(op_data),
      .op_done(op_done), .pop_data(pop_data), .wreg_wr(wreg_wr),
      .wreg_rd(wreg_rd), .wreg_idx(wreg_idx), .wreg_wdata(wreg_wdata),
      .wreg_rdata(wreg_rdata), .wreg_ack(wreg_ack), .dptr_wr(dptr_wr),
      .dptr_wdata(dptr_wdata), .dptr_value(dptr_value),
      .mode_select_pins(mode_select_pins), .prog_addr(prog_addr),
      .prog_rom_sel(prog_rom_sel), .in_system_prog(in_system_prog),
      .acc_value(acc_value), .psw_value(psw_value),
      .sp_value(sp_value), .reg_group(reg_group)
   );

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic finish_test();
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask

   task automatic give_up();
      failures++;
      $display("[ERR] %0t wait ran out", $time);
      finish_test();
   endtask

   task automatic do_reset();
      sys_rst = 1'b1;
      repeat (8) tick();
      sys_rst = 1'b0;
   endtask

   // Trailing tick keeps strobes from toggling twice in one step
   task automatic sfr(input logic w, input logic [7:0] a,
         input logic [7:0] d, input logic be, input logic [2:0] bs);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_bit_en = be;
      sfr_bit_sel = bs;
      sfr_wr = w;
      sfr_rd = !w;
      tick();
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      if (!w) chk(sfr_rd_ack, 1'b1);
      q = sfr_rdata;
      tick();
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr(1'b1, a, d, 1'b0, 3'h0);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      sfr(1'b0, a, 8'h00, 1'b0, 3'h0);
      chk(q, e);
   endtask

   task automatic op(input csfr_pkg::csfr_op_t c, input logic [7:0] d);
      int n;
      op_code = c;
      op_data = d;
      op_valid = 1'b1;
      tick();
      op_valid = 1'b0;
      for (n = 0; n < 3 && op_done !== 1'b1; n++) tick();
      if (op_done !== 1'b1) give_up();
      tick();
   endtask

   task automatic wreg(input logic w, input logic [2:0] i,
         input logic [7:0] d);
      int n;
      wreg_idx = i;
      wreg_wdata = d;
      wreg_wr = w;
      wreg_rd = !w;
      tick();
      wreg_wr = 1'b0;
      wreg_rd = 1'b0;
      for (n = 0; n < 3 && wreg_ack !== 1'b1; n++) tick();
      if (wreg_ack !== 1'b1) give_up();
      q = wreg_rdata;
      tick();
   endtask

   task automatic pm(input logic [15:0] a, input logic e);
      prog_addr = a;
      tick();
      chk(prog_rom_sel, e);
   endtask

   task automatic t_reset_rw();
      do_reset();
      for (int i = 0; i < 9; i++) rd_chk(REG_AD[71-8*i -: 8],
         RST_EXP[71-8*i -: 8]);
      for (int i = 0; i < 9; i++) wr(REG_AD[71-8*i -: 8], 8'hff);
      for (int i = 0; i < 9; i++) rd_chk(REG_AD[71-8*i -: 8],
         RW_EXP[71-8*i -: 8]);
      wr(8'ha2, 8'h00);
      rd_chk(8'h82, 8'hff);
      wr(8'hc0, 8'h00);
      rd_chk(8'hc0, 8'h00);
   endtask

   task automatic t_arith();
      logic [7:0] v;
      do_reset();
      for (int i = 0; i < 4; i++) begin
         v = 8'h35 + 8'h4b * i[7:0];
         wr(8'he0, v);
         chk(psw_value[0], ^v);
      end
      wr(8'he0, 8'hc8);
      wr(8'hf0, 8'h64);
      op(csfr_pkg::OP_MUL, 8'h00);
      rd_chk(8'hf0, 8'h4e);
      rd_chk(8'he0, 8'h20);
      wr(8'hf0, 8'h64);
      wr(8'he0, 8'h07);
      op(csfr_pkg::OP_DIV, 8'h00);
      rd_chk(8'he0, 8'h0e);
      rd_chk(8'hf0, 8'h02);
      wr(8'he0, 8'h7f);
      op(csfr_pkg::OP_ADD, 8'h01);
      chk(psw_value & 8'hc5, 8'h45);
      chk(acc_value, 8'h80);
      op(csfr_pkg::OP_SUBB, 8'h81);
      chk({acc_value, psw_value & 8'hc5}, 16'hffc0);
      op(csfr_pkg::OP_ADDC, 8'h01);
      chk({acc_value, psw_value & 8'hc5}, 16'h01c1);
   endtask

   task automatic t_stack();
      do_reset();
      op(csfr_pkg::OP_PUSH, 8'h5a);
      chk(sp_value, 8'h08);
      op(csfr_pkg::OP_PUSH, 8'ha5);
      op(csfr_pkg::OP_POP, 8'h00);
      chk({pop_data, sp_value}, 16'ha508);
      op(csfr_pkg::OP_POP, 8'h00);
      chk({pop_data, sp_value}, 16'h5a07);
      wr(8'h81, 8'h7e);
      op(csfr_pkg::OP_PUSH, 8'h3c);
      chk(sp_value, 8'h7f);
      op(csfr_pkg::OP_POP, 8'h00);
      chk({pop_data, sp_value}, 16'h3c7e);
   endtask

   task automatic t_pointers();
      do_reset();
      dptr_wdata = 16'h1234;
      dptr_wr = 1'b1;
      tick();
      dptr_wr = 1'b0;
      chk(dptr_value, 16'h1234);
      rd_chk(8'h83, 8'h12);
      wr(8'ha2, 8'h01);
      chk(dptr_value, 16'h0000);
      wr(8'h82, 8'hcd);
      chk(dptr_value, 16'h00cd);
      wr(8'ha2, 8'h00);
      chk(dptr_value, 16'h1234);
   endtask

   task automatic t_groups_bits();
      do_reset();
      wreg(1'b1, 3'h3, 8'h11);
      sfr(1'b1, 8'hd0, 8'h01, 1'b1, 3'h4);
      chk(reg_group, 2'h2);
      sfr(1'b0, 8'hd0, 8'h00, 1'b1, 3'h4);
      chk(q, 8'h01);
      wreg(1'b1, 3'h3, 8'h77);
      wr(8'hd0, 8'h00);
      wreg(1'b0, 3'h3, 8'h00);
      chk(q, 8'h11);
      sfr(1'b1, 8'h81, 8'h01, 1'b1, 3'h4);
      rd_chk(8'h81, 8'h07);
   endtask

   task automatic t_prog_map();
      do_reset();
      pm(16'hfc00, 1'b0);
      mode_select_pins = 3'h4;
      repeat (4) tick();
      chk(in_system_prog, 1'b1);
      rd_chk(8'hc0, 8'h12);
      pm(16'hfc00, 1'b1);
      pm(16'hfbff, 1'b0);
      pm(16'hffff, 1'b1);
      wr(8'hc0, 8'h00);
      pm(16'hffff, 1'b0);
      mode_select_pins = 3'h0;
      repeat (4) tick();
      chk(in_system_prog, 1'b0);
   endtask

   initial begin
      {sys_rst, sfr_wr, sfr_rd, sfr_bit_en, op_valid} = 5'h10;
      {wreg_wr, wreg_rd, dptr_wr} = 3'h0;
      {sfr_bit_sel, wreg_idx, mode_select_pins} = 9'h000;
      {sfr_addr, sfr_wdata, op_data, wreg_wdata} = 32'h0;
      {dptr_wdata, prog_addr} = 32'h0;
      op_code = csfr_pkg::OP_PUSH;
      failures = 0;
      comparisons = 0;
      t_reset_rw();
      t_arith();
      t_stack();
      t_pointers();
      t_groups_bits();
      t_prog_map();
      finish_test();
   end
endmodule // tb
